//--- tip_port_block.sv
// tip_port_block: five timed pin ports with serialisers, counters, clock blocks and APB access.
// assumes pins and strobes arrive asynchronously; the pad ring resolves o_pin/o_pin_oe.
//
// Notes on behaviour
// - ports of 1,4,8,16,32 bits, one direction
// - drive pins or sample, optional pin condition
// - every register access completes in one cycle
// - open drain drives zeros, floats ones
// - serialiser plus transfer register between pins, core
// - sixteen bit counter schedules pin transfers
// - counter readable; transfers deferred to chosen count
// - counter captured as timestamp on each transfer
// - enabled link disables port pins it shares
// - narrower enabled port wins overlapping pins
// - port always transfers at declared width
// - six clock blocks, block zero reference clock
// - clock block from pin, optionally divided
// - input strobe qualifies data, output strobe accompanies
// - reset attaches every port to block zero
// - pin events signalled straight to scheduler
`timescale 1ns/1ps

module tip_port_block
    import tip_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_psel,
    input  wire logic             i_penable,
    input  wire logic             i_pwrite,
    input  wire logic [7:0]       i_paddr,
    input  wire logic [31:0]      i_pwdata,
    output logic      [31:0]      o_prdata,
    output logic                  o_pready,
    output logic                  o_pslverr,
    input  wire logic [NPIN-1:0]  i_pin,
    output logic      [NPIN-1:0]  o_pin,
    output logic      [NPIN-1:0]  o_pin_oe,
    input  wire logic [NPORT-1:0] i_input_strobe,
    output logic      [NPORT-1:0] o_output_strobe,
    output logic      [NPORT-1:0] o_port_event,
    output logic                  o_irq
);

    // whole block state in one record
    typedef struct packed {
        tip_port_t [NPORT-1:0] port;
        tip_cb_t   [NCB-1:1]   cb;       // block 0 is the reference clock itself
        logic [NPIN-1:0]       pin_s1;   // synchroniser first stage
        logic [NPIN-1:0]       pin_s2;
        logic [NPORT-1:0]      stb_s1;
        logic [NPORT-1:0]      stb_s2;
        logic [NPORT-1:0]      status;   // sticky events
        logic [NPORT-1:0]      irqen;
        logic [NPORT-1:0]      evt;      // one-cycle event pulses
        logic                  link_en;
        logic                  irq;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
        logic [NPIN-1:0]       po;
        logic [NPIN-1:0]       poe;
    } tip_state_t;

    tip_state_t state_ff;  // registered state
    tip_state_t nxt_state; // next state

    // next state: synchronisers, clock blocks, bus, ports, pins
    always_comb begin
        logic [NCB-1:0]   tick;     // clock block ticks this cycle
        logic [NPORT-1:0] evs;      // events raised this cycle
        logic [NPORT-1:0] clr;      // status bits cleared by software
        logic [31:0]      rd;       // read data mux
        logic [31:0]      pv;       // own pins of a port, right aligned
        logic [31:0]      m;        // own pin mask
        logic [31:0]      sh;       // port value on pin positions
        logic [31:0]      sr_v;
        logic [5:0]       nb_v;
        logic [5:0]       nw;       // slices per word
        logic             hit;
        logic             ev;
        logic             tk;
        logic             tok;
        logic             cok;
        logic             setup;
        logic             acc;
        int               pidx;
        int               poff;
        tip_port_t        np;
        tick  = '0;
        evs   = '0;
        clr   = '0;
        rd    = '0;
        pv    = '0;
        m     = '0;
        sh    = '0;
        sr_v  = '0;
        nb_v  = '0;
        nw    = '0;
        hit   = 1'b0;
        ev    = 1'b0;
        tk    = 1'b0;
        tok   = 1'b0;
        cok   = 1'b0;
        np    = '0;
        pidx  = 0;
        poff  = 0;
        setup = 1'b0;
        acc   = 1'b0;
        nxt_state = state_ff;

        // two-stage synchronisers for pins and strobes
        nxt_state.pin_s1 = i_pin;
        nxt_state.pin_s2 = state_ff.pin_s1;
        nxt_state.stb_s1 = i_input_strobe;
        nxt_state.stb_s2 = state_ff.stb_s1;

        // clock blocks: block 0 ticks every reference cycle
        tick[0] = 1'b1;
        for (int c = 1; c < NCB; c++) begin
            // pin source counts rising edges of a synchronised pin
            ev = state_ff.cb[c].src ?
                 (state_ff.pin_s2[state_ff.cb[c].pin] & ~state_ff.cb[c].prev) : 1'b1;
            nxt_state.cb[c].prev = state_ff.pin_s2[state_ff.cb[c].pin];
            tick[c] = ev && (state_ff.cb[c].dcnt == state_ff.cb[c].div);
            if (ev) begin
                nxt_state.cb[c].dcnt = tick[c] ? 8'h00 : state_ff.cb[c].dcnt + 8'h01;
            end
        end

        // bus decode; addresses are byte offsets in 32-bit words
        pidx  = int'(i_paddr) / int'(A_PORT_STRIDE);
        poff  = int'(i_paddr) % int'(A_PORT_STRIDE);
        setup = i_psel && !i_penable;
        acc   = i_psel && i_penable && state_ff.pready;

        for (int p = 0; p < NPORT; p++) begin
            if (pidx == p) begin
                hit = 1'b1;
                case (8'(poff))
                    A_CTRL: begin
                        rd[C_EN]        = state_ff.port[p].en;
                        rd[C_DIR]       = state_ff.port[p].dir;
                        rd[C_OD]        = state_ff.port[p].od;
                        rd[C_SEN]       = state_ff.port[p].sen;
                        rd[C_COND +: 2] = state_ff.port[p].cond;
                        rd[C_CB +: 3]   = state_ff.port[p].cb;
                        rd[C_FULL]      = state_ff.port[p].xfull;
                    end
                    A_DATA:   rd = state_ff.port[p].xfer;
                    A_TIME:   rd = {16'h0000, state_ff.port[p].tcmp};
                    A_COUNT:  rd = {16'h0000, state_ff.port[p].cnt};
                    A_TSTAMP: rd = {16'h0000, state_ff.port[p].tstamp};
                    A_COND:   rd = state_ff.port[p].cval;
                    default:  hit = 1'b0;
                endcase
            end
        end
        for (int c = 1; c < NCB; c++) begin
            if (i_paddr == A_CB_BASE + 8'(c) * A_CB_STEP) begin
                hit               = 1'b1;
                rd[CB_SRC]        = state_ff.cb[c].src;
                rd[CB_PIN +: 5]   = state_ff.cb[c].pin;
                rd[CB_DIV +: 8]   = state_ff.cb[c].div;
            end
        end
        case (i_paddr)
            A_STATUS: begin
                hit = 1'b1;
                rd  = 32'(state_ff.status);
            end
            A_CLEAR: hit = 1'b1;           // write only, reads zero
            A_IRQEN: begin
                hit = 1'b1;
                rd  = 32'(state_ff.irqen);
            end
            A_LINK: begin
                hit = 1'b1;
                rd  = 32'(state_ff.link_en);
            end
            default: ;
        endcase

        // zero-wait slave: data latched in setup, ready in first access cycle
        nxt_state.pready = setup;
        if (setup) begin
            nxt_state.prdata  = hit ? rd : 32'h00000000;
            nxt_state.pslverr = ~hit;
        end

        // access edge: writes and read side effects, before port activity
        if (acc && hit) begin
            for (int p = 0; p < NPORT; p++) begin
                if (pidx == p) begin
                    if (i_pwrite) begin
                        case (8'(poff))
                            A_CTRL: begin
                                nxt_state.port[p].en   = i_pwdata[C_EN];
                                nxt_state.port[p].dir  = i_pwdata[C_DIR];
                                nxt_state.port[p].od   = i_pwdata[C_OD];
                                nxt_state.port[p].sen  = i_pwdata[C_SEN];
                                nxt_state.port[p].cond = tip_cond_t'(i_pwdata[C_COND +: 2]);
                                nxt_state.port[p].cb   = i_pwdata[C_CB +: 3];
                                nxt_state.port[p].nb   = '0;  // restart serialiser
                                nxt_state.port[p].ostb = 1'b0;
                            end
                            A_DATA: begin
                                // a full output word is not overwritten
                                if (state_ff.port[p].dir && !state_ff.port[p].xfull) begin
                                    nxt_state.port[p].xfer  = i_pwdata;
                                    nxt_state.port[p].xfull = 1'b1;
                                end
                            end
                            A_TIME: begin
                                nxt_state.port[p].tcmp = i_pwdata[15:0];
                                nxt_state.port[p].tarm = 1'b1;
                            end
                            A_COND:  nxt_state.port[p].cval = i_pwdata;
                            default: ;
                        endcase
                    end else if (8'(poff) == A_DATA && !state_ff.port[p].dir) begin
                        nxt_state.port[p].xfull = 1'b0;   // input word consumed
                    end
                end
            end
            for (int c = 1; c < NCB; c++) begin
                if (i_pwrite && i_paddr == A_CB_BASE + 8'(c) * A_CB_STEP) begin
                    nxt_state.cb[c].src  = i_pwdata[CB_SRC];
                    nxt_state.cb[c].pin  = i_pwdata[CB_PIN +: 5];
                    nxt_state.cb[c].div  = i_pwdata[CB_DIV +: 8];
                    nxt_state.cb[c].dcnt = 8'h00;
                end
            end
            if (i_pwrite) begin
                case (i_paddr)
                    A_CLEAR: clr = i_pwdata[NPORT-1:0];
                    A_IRQEN: nxt_state.irqen = i_pwdata[NPORT-1:0];
                    A_LINK:  nxt_state.link_en = i_pwdata[0];
                    default: ;
                endcase
            end
        end

        // ports: work on their own clock block tick
        for (int p = 0; p < NPORT; p++) begin
            np  = nxt_state.port[p];
            tk  = (state_ff.port[p].cb < 3'(NCB)) ? tick[state_ff.port[p].cb] : 1'b0;
            nw  = 6'(NPIN / PW[p]);
            pv  = (state_ff.pin_s2 >> PB[p]) & PM[p];
            // deferred transfer waits for the counter to hit the compare value
            tok = ~state_ff.port[p].tarm ||
                  (state_ff.port[p].cnt == state_ff.port[p].tcmp);
            case (state_ff.port[p].cond)
                COND_EQ: cok = (pv == (state_ff.port[p].cval & PM[p]));
                COND_NE: cok = (pv != (state_ff.port[p].cval & PM[p]));
                default: cok = 1'b1;
            endcase
            if (tk) begin
                np.cnt = state_ff.port[p].cnt + 16'h0001;
            end
            if (!state_ff.port[p].en) begin
                np.ostb = 1'b0;
            end else if (tk && state_ff.port[p].dir) begin
                // output: refill serialiser from transfer register, then shift
                sr_v    = state_ff.port[p].sr;
                nb_v    = state_ff.port[p].nb;
                np.ostb = 1'b0;
                if (nb_v == 6'h00 && state_ff.port[p].xfull && tok) begin
                    sr_v      = state_ff.port[p].xfer;
                    nb_v      = nw;
                    np.xfull  = 1'b0;
                    np.tarm   = 1'b0;
                    np.tstamp = state_ff.port[p].cnt;
                    evs[p]    = 1'b1;
                end
                if (nb_v != 6'h00) begin
                    np.pout = sr_v & PM[p];
                    sr_v    = sr_v >> PW[p];
                    nb_v    = nb_v - 6'h01;
                    np.ostb = 1'b1;
                end
                np.sr = sr_v;
                np.nb = nb_v;
            end else if (tk) begin
                // input: a word starts on condition and time, strobe gates each slice
                if ((~state_ff.port[p].sen || state_ff.stb_s2[p]) &&
                    (state_ff.port[p].nb != 6'h00 || (cok && tok))) begin
                    sr_v = (state_ff.port[p].sr >> PW[p]) | (pv << (NPIN - PW[p]));
                    nb_v = state_ff.port[p].nb + 6'h01;
                    if (nb_v == nw) begin
                        // an unread word is overwritten by the newer one
                        np.xfer   = sr_v;
                        np.xfull  = 1'b1;
                        np.tarm   = 1'b0;
                        np.tstamp = state_ff.port[p].cnt;
                        evs[p]    = 1'b1;
                        nb_v      = 6'h00;
                    end
                    np.sr = sr_v;
                    np.nb = nb_v;
                end
            end
            nxt_state.port[p] = np;
        end

        // pin ownership: widest first so narrower ports overwrite shared pins
        nxt_state.po  = '0;
        nxt_state.poe = '0;
        for (int p = NPORT - 1; p >= 0; p--) begin
            if (state_ff.port[p].en) begin
                m  = PM[p] << PB[p];
                sh = state_ff.port[p].pout << PB[p];
                nxt_state.poe = nxt_state.poe & ~m;
                nxt_state.po  = nxt_state.po & ~m;
                if (state_ff.port[p].dir) begin
                    // open drain only ever drives low
                    nxt_state.poe = nxt_state.poe |
                                    (state_ff.port[p].od ? (~sh & m) : m);
                    nxt_state.po  = nxt_state.po |
                                    (state_ff.port[p].od ? 32'h00000000 : (sh & m));
                end
            end
        end
        if (state_ff.link_en) begin
            nxt_state.poe = nxt_state.poe & ~LINK_PINS;
            nxt_state.po  = nxt_state.po & ~LINK_PINS;
        end

        // events: set wins over a clear in the same cycle
        nxt_state.evt    = evs;
        nxt_state.status = (state_ff.status & ~clr) | evs;
        nxt_state.irq    = |(nxt_state.status & nxt_state.irqen);
    end

    // state register; reset leaves every port on clock block 0
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from the state register
    assign o_prdata  = state_ff.prdata;
    assign o_pready  = state_ff.pready;
    assign o_pslverr = state_ff.pslverr;
    assign o_pin     = state_ff.po;
    assign o_pin_oe  = state_ff.poe;
    assign o_irq     = state_ff.irq;
    assign o_port_event = state_ff.evt;

    // output strobe sits in each port record
    for (genvar g = 0; g < NPORT; g++) begin : g_stb
        assign o_output_strobe[g] = state_ff.port[g].ostb;
    end

endmodule

//--- tip_pkg.sv
// tip_pkg: constants, register map and state types for the timed pin port block.
// assumes a single 100 MHz reference clock and an APB register slave with 8-bit addresses.
package tip_pkg;

    localparam int NPORT  = 5;            // ports of 1, 4, 8, 16 and 32 bits
    localparam int NCB    = 6;            // clock blocks per tile
    localparam int NPIN   = 32;           // pins shared by all ports
    localparam int REF_HZ = 100_000_000;  // reference clock, paces clock block 0

    // port widths, lowest pin and pin mask, narrowest first
    localparam int          PW [NPORT] = '{1, 4, 8, 16, 32};
    localparam int          PB [NPORT] = '{0, 4, 8, 16, 0};
    localparam logic [31:0] PM [NPORT] = '{32'h00000001, 32'h0000000F, 32'h000000FF,
                                           32'h0000FFFF, 32'hFFFFFFFF};

    // pins taken over by the inter-chip link when it is enabled
    localparam logic [31:0] LINK_PINS = 32'hFFFF0000;

    // register map, byte addresses; port p sits at p * A_PORT_STRIDE
    localparam logic [7:0] A_PORT_STRIDE = 8'h20;
    localparam logic [7:0] A_CTRL        = 8'h00;  // port control
    localparam logic [7:0] A_DATA        = 8'h04;  // transfer register
    localparam logic [7:0] A_TIME        = 8'h08;  // timed transfer compare value
    localparam logic [7:0] A_COUNT       = 8'h0C;  // port counter, read only
    localparam logic [7:0] A_TSTAMP      = 8'h10;  // timestamp, read only
    localparam logic [7:0] A_COND        = 8'h14;  // pin condition value
    localparam logic [7:0] A_CB_BASE     = 8'hC0;  // clock block c at base + 4 * c
    localparam logic [7:0] A_CB_STEP     = 8'h04;
    localparam logic [7:0] A_STATUS      = 8'hE0;  // sticky events, read only
    localparam logic [7:0] A_CLEAR       = 8'hE4;  // write one to clear, write only
    localparam logic [7:0] A_IRQEN       = 8'hE8;  // interrupt enables
    localparam logic [7:0] A_LINK        = 8'hEC;  // link enable

    // port control fields
    localparam int C_EN   = 0;
    localparam int C_DIR  = 1;   // 1 = output
    localparam int C_OD   = 2;   // open drain
    localparam int C_SEN  = 3;   // input strobe qualifies sampling
    localparam int C_COND = 4;   // two bits
    localparam int C_CB   = 8;   // three bits
    localparam int C_FULL = 16;  // transfer register full, read only

    // clock block fields
    localparam int CB_SRC = 0;   // 1 = pin source
    localparam int CB_PIN = 2;   // five bits
    localparam int CB_DIV = 8;   // eight bits, divide by value + 1

    typedef enum logic [1:0] {
        COND_NONE = 2'b00,
        COND_EQ   = 2'b01,
        COND_NE   = 2'b10
    } tip_cond_t;

    typedef struct packed {
        logic        en;
        logic        dir;
        logic        od;
        logic        sen;
        logic        tarm;    // timed transfer pending
        logic        xfull;   // transfer register holds a word
        logic        ostb;    // output strobe
        tip_cond_t   cond;
        logic [2:0]  cb;      // selected clock block
        logic [5:0]  nb;      // slices shifted so far / left
        logic [15:0] cnt;
        logic [15:0] tcmp;
        logic [15:0] tstamp;
        logic [31:0] xfer;
        logic [31:0] sr;      // serialiser
        logic [31:0] cval;
        logic [31:0] pout;    // value driven on own pins
    } tip_port_t;

    typedef struct packed {
        logic       src;
        logic [4:0] pin;
        logic [7:0] div;
        logic [7:0] dcnt;
        logic       prev;
    } tip_cb_t;

endpackage

//--- tip_port_block_sva.sv
// tip_port_block_sva: bus and pin checks on the port block's ports.
// assumes one clock domain with an asynchronous active-low reset; bound in.
`timescale 1ns/1ps
module tip_port_block_sva
    import tip_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_rstn,
    input wire logic             i_psel,
    input wire logic             i_penable,
    input wire logic [31:0]      o_prdata,
    input wire logic             o_pready,
    input wire logic             o_pslverr,
    input wire logic [NPIN-1:0]  o_pin_oe,
    input wire logic [NPORT-1:0] o_port_event,
    input wire logic             o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // setup phase of a bus transfer
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    // answer lasts exactly one cycle
    sequence answer_s;
        o_pready ##1 !o_pready;
    endsequence
    setup_answer_a: assert property (setup_s |=> answer_s)
        else $error("no single-cycle answer after setup");
    ready_cause_a: assert property (o_pready |-> $past(i_psel) && !$past(i_penable))
        else $error("answer without setup");
    rdata_hold_a: assert property (!i_psel |=> $stable(o_prdata))
        else $error("read data moved while idle");
    err_ready_a: assert property ($rose(o_pslverr) |-> o_pready)
        else $error("error flag without answer");
    reset_quiet_a: assert property ($rose(i_rstn) |-> !o_pready && o_pin_oe == '0
        && o_port_event == '0 && !o_irq) else $error("outputs busy after reset");
    // word events at least 9, 8 and 4 cycles apart on the 1-, 4- and 8-bit ports
    gap_bit_a: assert property (o_port_event[0] |=> !o_port_event[0] [*8])
        else $error("1-bit port words too close");
    gap_nib_a: assert property (o_port_event[1] |=> !o_port_event[1] [*7])
        else $error("4-bit port words too close");
    gap_byte_a: assert property (o_port_event[2] |=> !o_port_event[2] [*3])
        else $error("8-bit port words too close");
endmodule

//--- tip_pins_model.sv
// tip_pins_model: far-side hardware on the pads, pull-downs and input strobes.
// assumes the bench sets the far-side drive; strobes paced off the bench clock.
`timescale 1ns/1ps
module tip_pins_model
    import tip_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic [NPIN-1:0]  i_pin_drv,      // block drive values
    input  wire logic [NPIN-1:0]  i_pin_oe,       // block drive enables
    input  wire logic [NPIN-1:0]  i_ext_val,      // far-side values
    input  wire logic [NPIN-1:0]  i_ext_oe,       // far-side enables
    input  wire logic             i_slow,         // strobe one cycle in four
    output logic      [NPIN-1:0]  o_wire,         // resolved pad level
    output logic      [NPORT-1:0] o_input_strobe
);
    logic [1:0] ph_ff = 2'h0;  // strobe pacing phase
    // pull-downs: a released line settles low instead of keeping old data
    assign o_wire = (i_pin_oe & i_pin_drv) | (~i_pin_oe & i_ext_oe & i_ext_val);
    // free-running phase for the slow strobe
    always_ff @(posedge i_clk) begin
        ph_ff <= ph_ff + 2'h1;
    end
    // strobe qualifies what the far side presents
    assign o_input_strobe = {NPORT{!i_slow || ph_ff == 2'h0}};
endmodule

//--- tip_port_block_tb.sv
// tip_port_block_tb: register-level tests of the timed pin port block.
// assumes the pin model closes the pad loop; status bit p follows port p.
`timescale 1ns/1ps
module tip_port_block_tb;
    import tip_pkg::*;
    localparam logic [31:0] WORD = 32'hA5C30F96;  // irregular serial pattern
    logic             i_clk;
    logic             i_rstn;
    logic             i_psel;
    logic             i_penable;
    logic             i_pwrite;
    logic [7:0]       i_paddr;
    logic [31:0]      i_pwdata;
    logic [31:0]      o_prdata;
    logic             o_pready;
    logic             o_pslverr;
    logic [NPIN-1:0]  pin_wire;  // pad level
    logic [NPIN-1:0]  o_pin;
    logic [NPIN-1:0]  o_pin_oe;
    logic [NPIN-1:0]  ext_oe;    // far-side enables
    logic [NPORT-1:0] strobe_in;
    logic [NPORT-1:0] o_output_strobe;
    logic [NPORT-1:0] o_port_event;
    logic             o_irq;
    logic [31:0]      q;
    logic             e;
    logic             hit;
    logic [15:0]      t;
    logic [35:0]      bits;
    realtime          t0;
    int               n_fail;
    int               samples_checked;
    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    tip_port_block i_dut (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_pin(pin_wire), .o_pin, .o_pin_oe,
        .i_input_strobe(strobe_in), .o_output_strobe, .o_port_event, .o_irq);
    tip_pins_model i_model (.i_clk, .i_pin_drv(o_pin), .i_pin_oe(o_pin_oe),
        .i_ext_val(32'h3C5A0000), .i_ext_oe(ext_oe), .i_slow(1'b1), .o_wire(pin_wire),
        .o_input_strobe(strobe_in));
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h want %h", $time, s, got, exp);
        end
    endtask
    // one transfer; an idle edge first so psel never changes twice at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        @(posedge i_clk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        check({31'h0, o_pready}, 32'h1, "bus answer");
        if (n >= 50) conclude();
        rq = o_prdata;
        re = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, q, e);
    endtask
    function automatic logic [7:0] pa(input int p, input logic [7:0] off);
        return A_PORT_STRIDE * 8'(p) + off;
    endfunction
    // bounded wait for irq (sel 0) or pin enables (sel 1) to reach a value
    task automatic settle(input logic sel, input logic [31:0] exp, input string s);
        for (int n = 0; n < 8 && (sel ? o_pin_oe : {31'h0, o_irq}) !== exp; n++) begin
            @(posedge i_clk);
        end
        check(sel ? o_pin_oe : {31'h0, o_irq}, exp, s);
    endtask
    // bounded wait for a port's word event
    task automatic await_event(input int p);
        hit = 1'b0;
        for (int n = 0; n < 200 && !hit; n++) begin
            @(posedge i_clk);
            hit = (o_port_event[p] === 1'b1);
        end
        check({31'h0, hit}, 32'h1, "word event");
    endtask
    initial begin
        {i_rstn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, ext_oe} = '0;
        n_fail = 0;
        samples_checked = 0;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(pa(0, A_CTRL));
        check(q, 32'h0, "ctrl after reset");
        rd(8'hF0);
        check({q[31:1], e}, 32'h1, "unmapped access");
        $display("reset and map test done");
        wr(pa(4, A_CTRL), 32'h101);
        rd(pa(4, A_COUNT));
        t0 = $realtime;
        t = q[15:0];
        rd(pa(4, A_COUNT));
        check({16'h0, q[15:0] - t}, 32'(int'(($realtime - t0) / 10.0)), "count");
        wr(pa(4, A_CTRL), 32'h0);
        wr(A_CLEAR, 32'hFFFFFFFF);
        $display("counter test done");
        // push-pull then open drain: timed word, serial bits, timestamp
        for (int od = 0; od < 2; od++) begin
            wr(pa(0, A_CTRL), od ? 32'h7 : 32'h3);
            rd(pa(0, A_COUNT));
            t = q[15:0] + 16'h0028;
            wr(pa(0, A_TIME), {16'h0, t});
            wr(pa(0, A_DATA), WORD);
            await_event(0);
            check({31'h0, o_output_strobe[0]}, 32'h1, "strobe with data");
            for (int k = 0; k < 36; k++) begin
                @(posedge i_clk);
                bits[k] = od ? ~o_pin_oe[0] : pin_wire[0];
            end
            check({31'h0, o_output_strobe[0]}, 32'h0, "strobe idle");
            hit = 1'b0;
            for (int k = 0; k < 4; k++) hit |= (bits[k +: 32] === WORD);
            check({31'h0, hit}, 32'h1, "serial word");
            rd(pa(0, A_TSTAMP));
            check(q, {16'h0, t}, "timestamp");
        end
        $display("timed output test done");
        rd(A_STATUS);
        check(q, 32'h1, "status");
        settle(1'b0, 32'h0, "irq masked");
        wr(A_IRQEN, 32'h1);
        settle(1'b0, 32'h1, "irq raised");
        wr(A_CLEAR, 32'h1);
        settle(1'b0, 32'h0, "irq cleared");
        rd(A_CLEAR);
        check(q, 32'h0, "clear reads zero");
        $display("interrupt test done");
        wr(pa(0, A_CTRL), 32'h0);
        wr(pa(4, A_CTRL), 32'h3);
        wr(pa(1, A_CTRL), 32'h1);
        wr(pa(2, A_CTRL), 32'h1);
        settle(1'b1, 32'hFFFF000F, "narrow port wins");
        wr(A_LINK, 32'h1);
        settle(1'b1, 32'h0000000F, "link masks pins");
        wr(A_LINK, 32'h0);
        {ext_oe} <= 32'hFFFF0000;
        wr(pa(4, A_CTRL), 32'h0);
        wr(pa(1, A_CTRL), 32'h0);
        wr(pa(3, A_CTRL), 32'h9);
        await_event(3);
        rd(pa(3, A_DATA));
        check(q, 32'h3C5A3C5A, "input word");
        $display("pin sharing and input test done");
        conclude();
    end
endmodule
bind tip_port_block tip_port_block_sva i_sva (.i_clk, .i_rstn, .i_psel, .i_penable,
    .o_prdata, .o_pready, .o_pslverr, .o_pin_oe, .o_port_event, .o_irq);
